// >>> rtl/radio_link_regs.svh
`ifndef RADIO_LINK_REGS_SVH
`define RADIO_LINK_REGS_SVH
// register byte offsets
`define RL_CTRL 8'h00
`define RL_MODE 8'h04
`define RL_TX_ADDR 8'h08
`define RL_RX_ADDR 8'h0c
`define RL_PAUSE 8'h10
`define RL_STATUS 8'h14
// ctrl fields
`define RL_CTRL_RPT 0
`define RL_CTRL_TX_ADDR_EN 1
`define RL_CTRL_RX_ADDR_EN 2
`define RL_CTRL_NATIVE_FEC 3
// reset values
`define RL_TX_ADDR_RST 16'h00ff
`define RL_RX_ADDR_RST 16'h0000
`define RL_BROADCAST 16'h00ff
`define RL_PAUSE_RST 8'h03
// serial byte interval: clock rate, baud, bits per byte
`define RL_CLK_HZ 100000000
`define RL_BAUD 9600
`define RL_BYTE_BITS 10
`define RL_BYTE_CYCLES ((`RL_CLK_HZ * `RL_BYTE_BITS) / `RL_BAUD)
`endif

// >>> rtl/radio_link_pkg.sv
package radio_link_pkg;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_RPT = 2'b01,
		TX_SER = 2'b11
	} tx_state_e;
	typedef enum logic [3:0] {
		FAM_NONE = 4'h0,
		FAM_4L_NATIVE = 4'h1,
		FAM_8L = 4'h2,
		FAM_16L = 4'h3,
		FAM_LEGACY = 4'h4,
		FAM_4L_TP = 4'h5,
		FAM_GMSK_TP = 4'h6,
		FAM_FAST_4L = 4'h7,
		FAM_GMSK_TUNED = 4'h8,
		FAM_VENDOR = 4'h9,
		FAM_MARITIME = 4'ha
	} family_e;
	typedef struct packed {
		logic valid;
		family_e family;
		logic fec;
		logic scramble;
		logic narrow;
		logic alt_rx;
		logic third_party;
	} mode_s;
	typedef struct packed {
		logic [7:0] data;
		logic last;
		logic [15:0] dest;
		logic [7:0] chan;
	} rf_frame_s;
endpackage

// >>> rtl/radio_repeater_compat_select.sv
`timescale 1ns/1ps
`include "radio_link_regs.svh"
// Overview of operation
// - repeat buffer holds packets up to 1kB
// - received data goes to serial and buffer
// - retransmit buffered packet on receive channel
// - serial input data transmitted normally
// - decode native codes 0,20,21,22,6
// - decode third-party four-level codes 1,23,26,28
// - decode third-party gmsk codes 2,24,27,29
// - decode fast four-level codes 5, 25
// - codes 3,4 tuned gmsk; 8 vendor mode
// - decode maritime codes 34 to 37
// - transmit address is destination, reset 0x00ff
// - receive address is local address, reset 0
// - accept own address or broadcast 255
// - native fec setting affects only code 0
// - sent once, no retry or acknowledge
// - pause length counted in byte intervals
// - third-party modes send after serial gap
module radio_repeater_compat_select #(
	parameter int DEPTH = 1024,
	parameter int BYTE_CYCLES = `RL_BYTE_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite register slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// serial host port
	input wire logic ser_in_valid,
	input wire logic [7:0] ser_in_data,
	output logic ser_in_ready,
	output logic ser_out_valid,
	output logic [7:0] ser_out_data,
	// radio receive and transmit
	input wire logic rf_rx_valid,
	input wire radio_link_pkg::rf_frame_s rf_rx,
	output logic rf_tx_valid,
	output radio_link_pkg::rf_frame_s rf_tx,
	input wire logic rf_tx_ready,
	// decoded compatibility mode
	output radio_link_pkg::mode_s mode_out
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [16:0] BC_LAST = 17'(BYTE_CYCLES - 1);

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_have;
		logic w_have;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic [3:0] ctrl;
		logic [5:0] code;
		logic [15:0] tx_addr;
		logic [15:0] rx_addr;
		logic [7:0] pause;
		logic ovf_flag;
		radio_link_pkg::mode_s mode;
		logic [AW:0] rpt_cnt;
		logic rpt_ovf;
		logic rpt_pend;
		logic [AW:0] rpt_len;
		logic [AW:0] rpt_rd;
		logic [15:0] rpt_dest;
		logic [7:0] rpt_chan;
		logic [AW:0] ser_wr;
		logic [AW:0] ser_rd;
		logic [16:0] gap_cyc;
		logic [7:0] gap_bytes;
		logic gap_done;
		logic ser_rdy;
		radio_link_pkg::tx_state_e tx_state;
		logic tx_rpt;
		logic tx_valid;
		radio_link_pkg::rf_frame_s tx;
		logic out_valid;
		logic [7:0] out_data;
	} st_s;

	st_s st;
	st_s next_st;
	logic [7:0] rpt_mem [DEPTH];
	logic [7:0] ser_mem [DEPTH];
	logic rx_accept;
	logic rpt_store;
	logic ser_take;

	function automatic radio_link_pkg::mode_s decode(input logic [5:0] c, input logic nfec);
		radio_link_pkg::mode_s m;
		m = '0;
		m.valid = 1'b1;
		case (c)
			6'h00: begin m.family = radio_link_pkg::FAM_4L_NATIVE; m.fec = nfec; end
			6'h14: m.family = radio_link_pkg::FAM_8L;
			6'h15: begin m.family = radio_link_pkg::FAM_8L; m.fec = 1'b1; end
			6'h16: begin m.family = radio_link_pkg::FAM_16L; m.fec = 1'b1; end
			6'h06: m.family = radio_link_pkg::FAM_LEGACY;
			6'h01: begin m.family = radio_link_pkg::FAM_4L_TP; m.fec = 1'b1; m.scramble = 1'b1; end
			6'h17: begin m.family = radio_link_pkg::FAM_4L_TP; m.scramble = 1'b1; end
			6'h1a: m.family = radio_link_pkg::FAM_4L_TP;
			6'h1c: begin m.family = radio_link_pkg::FAM_4L_TP; m.fec = 1'b1; end
			6'h02: begin m.family = radio_link_pkg::FAM_GMSK_TP; m.fec = 1'b1; m.scramble = 1'b1; end
			6'h18: begin m.family = radio_link_pkg::FAM_GMSK_TP; m.scramble = 1'b1; end
			6'h1b: m.family = radio_link_pkg::FAM_GMSK_TP;
			6'h1d: begin m.family = radio_link_pkg::FAM_GMSK_TP; m.fec = 1'b1; end
			6'h05: begin m.family = radio_link_pkg::FAM_FAST_4L; m.fec = 1'b1; end
			6'h19: m.family = radio_link_pkg::FAM_FAST_4L;
			6'h03: m.family = radio_link_pkg::FAM_GMSK_TUNED;
			6'h04: begin m.family = radio_link_pkg::FAM_GMSK_TUNED; m.alt_rx = 1'b1; end
			6'h08: m.family = radio_link_pkg::FAM_VENDOR;
			6'h22: begin m.family = radio_link_pkg::FAM_MARITIME; m.fec = 1'b1; end
			6'h23: begin m.family = radio_link_pkg::FAM_MARITIME; m.fec = 1'b1; m.narrow = 1'b1; end
			6'h24: m.family = radio_link_pkg::FAM_MARITIME;
			6'h25: begin m.family = radio_link_pkg::FAM_MARITIME; m.narrow = 1'b1; end
			default: m.valid = 1'b0;
		endcase
		m.third_party = m.family inside {radio_link_pkg::FAM_4L_TP, radio_link_pkg::FAM_GMSK_TP,
			radio_link_pkg::FAM_FAST_4L, radio_link_pkg::FAM_GMSK_TUNED};
		return m;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// the packet dest travels in the frame; a disabled filter takes everything
	assign rx_accept = !st.ctrl[`RL_CTRL_RX_ADDR_EN] || rf_rx.dest == st.rx_addr
		|| rf_rx.dest == `RL_BROADCAST;
	// a packet arriving while the last one is still queued is passed on but not repeated
	assign rpt_store = rf_rx_valid && rx_accept && st.ctrl[`RL_CTRL_RPT] && !st.rpt_pend
		&& st.rpt_cnt != FULL;
	assign ser_take = ser_in_valid && st.ser_rdy;

	always_comb begin
		logic [31:0] w;
		logic [AW:0] one;
		logic send;
		w = '0;
		one = (AW+1)'(1);
		send = !st.tx_valid || rf_tx_ready;
		next_st = st;
		// register writes, address and data in either order
		if (awvalid && st.awready) begin
			next_st.aw_have = 1'b1;
			next_st.aw_addr = awaddr;
		end
		if (wvalid && st.wready) begin
			next_st.w_have = 1'b1;
			next_st.w_data = wdata;
			next_st.w_strb = wstrb;
		end
		if (st.aw_have && st.w_have) begin
			next_st.aw_have = 1'b0;
			next_st.w_have = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = 2'b00;
			case (st.aw_addr)
				`RL_CTRL: begin
					w = merge({28'h0, st.ctrl}, st.w_data, st.w_strb);
					next_st.ctrl = w[3:0];
				end
				`RL_MODE: begin
					w = merge({26'h0, st.code}, st.w_data, st.w_strb);
					next_st.code = w[5:0];
				end
				`RL_TX_ADDR: begin
					w = merge({16'h0, st.tx_addr}, st.w_data, st.w_strb);
					next_st.tx_addr = w[15:0];
				end
				`RL_RX_ADDR: begin
					w = merge({16'h0, st.rx_addr}, st.w_data, st.w_strb);
					next_st.rx_addr = w[15:0];
				end
				`RL_PAUSE: begin
					w = merge({24'h0, st.pause}, st.w_data, st.w_strb);
					next_st.pause = w[7:0];
				end
				`RL_STATUS: begin
					if (st.w_strb[0] && st.w_data[0]) begin
						next_st.ovf_flag = 1'b0;
					end
				end
				default: next_st.bresp = 2'b10;
			endcase
		end
		if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end
		next_st.awready = !next_st.aw_have && !next_st.bvalid;
		next_st.wready = !next_st.w_have && !next_st.bvalid;
		// register reads
		if (arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = 2'b00;
			case (araddr)
				`RL_CTRL: next_st.rdata = {28'h0, st.ctrl};
				`RL_MODE: next_st.rdata = {26'h0, st.code};
				`RL_TX_ADDR: next_st.rdata = {16'h0, st.tx_addr};
				`RL_RX_ADDR: next_st.rdata = {16'h0, st.rx_addr};
				`RL_PAUSE: next_st.rdata = {24'h0, st.pause};
				`RL_STATUS: next_st.rdata = {18'h0, st.mode, st.tx_state, st.rpt_pend, st.ovf_flag};
				default: begin
					next_st.rdata = '0;
					next_st.rresp = 2'b10;
				end
			endcase
		end else if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end
		next_st.arready = !next_st.rvalid;
		next_st.mode = decode(st.code, st.ctrl[`RL_CTRL_NATIVE_FEC]);
		// radio receive: accepted packets always to serial, optionally into repeat buffer
		next_st.out_valid = rf_rx_valid && rx_accept;
		next_st.out_data = rf_rx.data;
		if (rf_rx_valid && rx_accept && st.ctrl[`RL_CTRL_RPT] && !st.rpt_pend) begin
			if (rpt_store) begin
				next_st.rpt_cnt = st.rpt_cnt + one;
			end else begin
				next_st.rpt_ovf = 1'b1;
			end
			next_st.rpt_dest = rf_rx.dest;
			next_st.rpt_chan = rf_rx.chan;
			if (rf_rx.last) begin
				next_st.rpt_cnt = '0;
				next_st.rpt_ovf = 1'b0;
				if (rpt_store && !st.rpt_ovf) begin
					next_st.rpt_pend = 1'b1;
					next_st.rpt_len = st.rpt_cnt + one;
				end else begin
					next_st.ovf_flag = 1'b1;
				end
			end
		end
		// serial input collected; end of message is a pause of whole byte intervals
		if (ser_take) begin
			next_st.ser_wr = st.ser_wr + one;
			next_st.gap_cyc = '0;
			next_st.gap_bytes = '0;
		end else if (st.ser_wr != '0 && !st.gap_done) begin
			next_st.gap_cyc = st.gap_cyc + 17'h00001;
			if (st.gap_cyc == BC_LAST) begin
				next_st.gap_cyc = '0;
				next_st.gap_bytes = st.gap_bytes + 8'h01;
				if (st.gap_bytes + 8'h01 >= st.pause) begin
					next_st.gap_done = 1'b1;
				end
			end
		end
		// radio transmit; each frame goes out once and is never resent
		if (send) begin
			next_st.tx_valid = 1'b0;
			case (st.tx_state)
				radio_link_pkg::TX_IDLE: begin
					if (st.rpt_pend) begin
						next_st.tx_state = radio_link_pkg::TX_RPT;
						next_st.rpt_rd = '0;
					end else if (st.ser_wr != '0 && (st.gap_done || !st.mode.third_party)) begin
						next_st.tx_state = radio_link_pkg::TX_SER;
					end
				end
				radio_link_pkg::TX_RPT: begin
					next_st.tx_valid = 1'b1;
					next_st.tx_rpt = 1'b1;
					next_st.tx.data = rpt_mem[st.rpt_rd[AW-1:0]];
					next_st.tx.last = st.rpt_rd + one == st.rpt_len;
					next_st.tx.dest = st.rpt_dest;
					next_st.tx.chan = st.rpt_chan;
					next_st.rpt_rd = st.rpt_rd + one;
					if (next_st.tx.last) begin
						next_st.rpt_pend = 1'b0;
						next_st.tx_state = radio_link_pkg::TX_IDLE;
					end
				end
				radio_link_pkg::TX_SER: begin
					// the last byte waits for the pause so it can carry the end mark
					if (st.ser_rd + one < st.ser_wr || (st.gap_done && st.ser_rd < st.ser_wr)) begin
						next_st.tx_valid = 1'b1;
						next_st.tx_rpt = 1'b0;
						next_st.tx.data = ser_mem[st.ser_rd[AW-1:0]];
						next_st.tx.last = st.gap_done && st.ser_rd + one == st.ser_wr;
						next_st.tx.dest = st.ctrl[`RL_CTRL_TX_ADDR_EN] ? st.tx_addr
							: `RL_BROADCAST;
						next_st.tx.chan = '0;
						next_st.ser_rd = st.ser_rd + one;
						if (next_st.tx.last) begin
							next_st.ser_wr = '0;
							next_st.ser_rd = '0;
							next_st.gap_done = 1'b0;
							next_st.gap_bytes = '0;
							next_st.tx_state = radio_link_pkg::TX_IDLE;
						end
					end
				end
				default: next_st.tx_state = radio_link_pkg::TX_IDLE;
			endcase
		end
		next_st.ser_rdy = next_st.ser_wr != FULL && !next_st.gap_done;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.tx_addr <= `RL_TX_ADDR_RST;
			st.rx_addr <= `RL_RX_ADDR_RST;
			st.pause <= `RL_PAUSE_RST;
			st.tx_state <= radio_link_pkg::TX_IDLE;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge aclk) begin
		if (rpt_store) begin
			rpt_mem[st.rpt_cnt[AW-1:0]] <= rf_rx.data;
		end
		if (ser_take) begin
			ser_mem[st.ser_wr[AW-1:0]] <= ser_in_data;
		end
	end

	assign awready = st.awready;
	assign wready = st.wready;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign arready = st.arready;
	assign rvalid = st.rvalid;
	assign rresp = st.rresp;
	assign rdata = st.rdata;
	assign ser_in_ready = st.ser_rdy;
	assign ser_out_valid = st.out_valid;
	assign ser_out_data = st.out_data;
	assign rf_tx_valid = st.tx_valid;
	assign rf_tx = st.tx;
	assign mode_out = st.mode;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_bcast_accept: assert property (rf_rx_valid && rf_rx.dest == 16'h00ff |=> ser_out_valid)
		else $error("broadcast packet not delivered");
	a_rx_filter: assert property (rf_rx_valid && st.ctrl[2] && rf_rx.dest != st.rx_addr
		&& rf_rx.dest != 16'h00ff |=> !ser_out_valid)
		else $error("foreign packet delivered");
	a_tx_dest: assert property (rf_tx_valid && !st.tx_rpt && st.ctrl[1]
		|-> rf_tx.dest == st.tx_addr)
		else $error("serial frame has wrong destination");
	a_rpt_chan: assert property (rf_tx_valid && st.tx_rpt |-> rf_tx.chan == st.rpt_chan)
		else $error("repeat on wrong channel");
	a_mode_eight: assert property (st.code == 6'h14
		|=> mode_out.family == radio_link_pkg::FAM_8L && !mode_out.fec)
		else $error("code 20 decoded wrongly");
	a_native_fec: assert property (st.code == 6'h00 |=> mode_out.fec == $past(st.ctrl[3]))
		else $error("native fec not followed");
	// the last byte clears the pause flag as it launches, so it may stand after it
	a_tp_gap: assert property (rf_tx_valid && !st.tx_rpt && mode_out.third_party
		&& $stable(mode_out) |-> st.gap_done || rf_tx.last)
		else $error("third-party frame sent before pause");
	a_ovf_drop: assert property ((st.rpt_ovf || st.rpt_cnt == FULL) && rf_rx_valid
		&& rf_rx.last && rx_accept && st.ctrl[0] && !st.rpt_pend
		|=> !st.rpt_pend && st.rpt_cnt == '0)
		else $error("oversize packet queued for repeat");
endmodule // radio_repeater_compat_select

// >>> test/peer_radio_model.sv
`timescale 1ns/1ps
module peer_radio_model (
	// clock and pacing
	input wire logic aclk,
	input wire logic slow,
	// toward the block's radio receive side
	output logic rf_rx_valid,
	output radio_link_pkg::rf_frame_s rf_rx,
	// from the block's radio transmit side
	input wire logic rf_tx_valid,
	input wire radio_link_pkg::rf_frame_s rf_tx,
	output logic rf_tx_ready
);
	logic [7:0] pkt[$];
	radio_link_pkg::rf_frame_s got[$];
	logic [1:0] pace;
	initial begin
		rf_rx_valid = 1'h0;
		rf_rx = '0;
		rf_tx_ready = 1'h0;
		pace = 2'h0;
	end
	// slow pacing takes one byte in four, so the block must hold its byte
	always @(posedge aclk) begin
		pace <= pace + 2'h1;
		rf_tx_ready <= !slow || pace == 2'h3;
		if (rf_tx_valid === 1'b1 && rf_tx_ready) got.push_back(rf_tx);
	end
	// one peer on a shared fec and scrambling choice; no chains, so no loops
	task send(input logic [15:0] d, input logic [7:0] c);
		for (int i = 0; i < pkt.size(); i++) begin
			rf_rx_valid <= 1'h1;
			rf_rx <= '{pkt[i], i == pkt.size() - 1, d, c};
			@(posedge aclk);
		end
		rf_rx_valid <= 1'h0;
		// idle lines show no stale frame
		rf_rx <= ~rf_rx;
	endtask
endmodule // peer_radio_model

// >>> test/test_radio_repeater_compat_select.sv
`timescale 1ns/1ps
`include "radio_link_regs.svh"
module test_radio_repeater_compat_select;
	localparam int DEPTH = 16;
	localparam int BYTE_CYCLES = 4;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow, awready, wready, bvalid;
	logic arready, rvalid, ser_in_valid, ser_in_ready, ser_out_valid, rf_rx_valid, rf_tx_valid;
	logic rf_tx_ready;
	logic [7:0] awaddr, araddr, ser_in_data, ser_out_data;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rr, br;
	logic [19:0] em;
	logic [5:0] cd;
	radio_link_pkg::rf_frame_s rf_rx, rf_tx;
	radio_link_pkg::mode_s mode_out;
	logic [7:0] so_q[$], ex[$];
	int codes[23] = '{0, 20, 21, 22, 6, 1, 23, 26, 28, 2, 24, 27, 29, 5, 25, 3, 4, 8, 34, 35, 36, 37, 7};
	int bad_count, tests_run, cyc;
	integer seed = 32'h1a2e5969;
	logic [15:0] dst;
	logic [7:0] ch;
	radio_repeater_compat_select #(.DEPTH(DEPTH), .BYTE_CYCLES(BYTE_CYCLES))
		radio_repeater_compat_select_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .ser_in_valid, .ser_in_data, .ser_in_ready, .ser_out_valid,
		.ser_out_data, .rf_rx_valid, .rf_rx, .rf_tx_valid, .rf_tx, .rf_tx_ready, .mode_out);
	peer_radio_model peer_radio_model_i (.aclk, .slow, .rf_rx_valid, .rf_rx, .rf_tx_valid,
		.rf_tx, .rf_tx_ready);
	initial begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (ser_out_valid === 1'b1) so_q.push_back(ser_out_data);
		if (cyc == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	task print_verdict();
		$display("counts: %0d compared, %0d mismatched", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task chk_val(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_frame(input radio_link_pkg::rf_frame_s g, input radio_link_pkg::rf_frame_s e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'b1);
		br = bresp;
	endtask
	task rdr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rr = rresp;
	endtask
	// mask in the upper half: fields the rules leave open are not compared
	function automatic logic [19:0] exp_mode(input logic [5:0] c, input logic nf);
		radio_link_pkg::mode_s m;
		logic [9:0] k;
		m = '0;
		k = 10'h3f1;
		m.valid = 1'h1;
		m.third_party = c inside {[1:5], [23:29]};
		case (c)
			0: begin m.family = radio_link_pkg::FAM_4L_NATIVE; m.fec = nf; end
			20, 21: begin m.family = radio_link_pkg::FAM_8L; m.fec = c[0]; end
			22: begin m.family = radio_link_pkg::FAM_16L; m.fec = 1'h1; end
			6: m.family = radio_link_pkg::FAM_LEGACY;
			1, 23, 26, 28: begin
				m.family = radio_link_pkg::FAM_4L_TP;
				m.fec = c == 1 || c == 28;
				m.scramble = c == 1 || c == 23;
				k = 10'h3f9;
			end
			2, 24, 27, 29: begin
				m.family = radio_link_pkg::FAM_GMSK_TP;
				m.fec = c == 2 || c == 29;
				m.scramble = c == 2 || c == 24;
				k = 10'h3f9;
			end
			5, 25: begin m.family = radio_link_pkg::FAM_FAST_4L; m.fec = c == 5; end
			3, 4: begin m.family = radio_link_pkg::FAM_GMSK_TUNED; k = 10'h3e1; end
			8: begin m.family = radio_link_pkg::FAM_VENDOR; k = 10'h3e1; end
			34, 35, 36, 37: begin
				m.family = radio_link_pkg::FAM_MARITIME;
				m.fec = c < 36;
				m.narrow = c[0];
				k = 10'h3f5;
			end
			default: begin m = '0; k = 10'h200; end
		endcase
		return {k, m};
	endfunction
	task rx_pkt(input int len, input logic [15:0] d, input logic ok);
		ex.delete();
		repeat (len) ex.push_back(8'($random(seed)));
		peer_radio_model_i.pkt = ex;
		peer_radio_model_i.send(d, ch);
		repeat (2) @(posedge aclk);
		chk_val(so_q.size(), ok ? len : 0);
		if (ok) foreach (so_q[k]) chk_val(so_q[k], ex[k]);
		so_q.delete();
	endtask
	task chk_tx(input logic [15:0] d, input logic [7:0] c);
		while (peer_radio_model_i.got.size() < ex.size()) @(posedge aclk);
		repeat (40) @(posedge aclk);
		chk_val(peer_radio_model_i.got.size(), ex.size());
		foreach (ex[k]) chk_frame(peer_radio_model_i.got[k], '{ex[k], k == ex.size() - 1, d, c});
		peer_radio_model_i.got.delete();
	endtask
	task ser_send(input int len);
		ex.delete();
		for (int i = 0; i < len; i++) begin
			ex.push_back(8'($random(seed)));
			ser_in_data <= ex[i];
			ser_in_valid <= 1'h1;
			do @(posedge aclk); while (ser_in_ready !== 1'b1);
		end
		ser_in_valid <= 1'h0;
		ser_in_data <= ~ser_in_data;
	endtask
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, ser_in_valid, slow} = 8'h0;
		{awaddr, araddr, ser_in_data, wdata, wstrb} = '0;
		wstrb = 4'hf;
		{bad_count, tests_run, ch} = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		rdr(`RL_CTRL); chk_val(rd, 32'h0);
		rdr(`RL_TX_ADDR); chk_val(rd, 32'h00ff);
		rdr(`RL_RX_ADDR); chk_val(rd, 32'h0);
		rdr(`RL_PAUSE); chk_val(rd, 32'h3);
		rdr(8'h40); chk_val({30'h0, rr}, 32'h2);
		wr(8'h40, 32'h1); chk_val({30'h0, br}, 32'h2);
		$display("test reset done");
		// addressing stays off while every code is decoded, native fec off then on
		for (int nf = 0; nf < 2; nf++) begin
			wr(`RL_CTRL, nf << 3);
			for (int k = 0; k < 24; k++) begin
				cd = k < 23 ? 6'(codes[k]) : 6'($random(seed));
				wr(`RL_MODE, cd);
				repeat (2) @(posedge aclk);
				em = exp_mode(cd, nf[0]);
				chk_val(mode_out & em[19:10], em[9:0]);
			end
		end
		$display("test mode decode done");
		wr(`RL_MODE, 32'h0); wr(`RL_CTRL, 32'h4); wr(`RL_RX_ADDR, 32'h5);
		chk_val({30'h0, br}, 32'h0);
		rx_pkt(3, 16'h0005, 1'h1);
		rx_pkt(2, 16'h0007, 1'h0);
		rx_pkt(4, 16'h00ff, 1'h1);
		$display("test address filter done");
		wr(`RL_CTRL, 32'h1);
		slow <= 1'h1;
		for (int k = 0; k < 3; k++) begin
			dst = 16'($random(seed));
			ch = 8'($random(seed));
			rx_pkt(k == 0 ? DEPTH : 1 + {$random(seed)} % DEPTH, dst, 1'h1);
			chk_tx(dst, ch);
		end
		rx_pkt(DEPTH + 1, dst, 1'h1);
		ex.delete();
		chk_tx(dst, ch);
		rdr(`RL_STATUS); chk_val(rd[0], 1'h1);
		wr(`RL_STATUS, 32'h1);
		rdr(`RL_STATUS); chk_val(rd[0], 1'h0);
		rx_pkt(3, dst, 1'h1);
		chk_tx(dst, ch);
		$display("test repeater done");
		// third-party framing waits for the pause and goes to the transmit address
		wr(`RL_CTRL, 32'h2); wr(`RL_TX_ADDR, 32'h42); wr(`RL_MODE, 32'h1);
		slow <= 1'h0;
		ser_send(3);
		repeat (3 * BYTE_CYCLES) @(posedge aclk);
		chk_val(peer_radio_model_i.got.size(), 0);
		chk_tx(16'h0042, 8'h0);
		wr(`RL_CTRL, 32'h1); wr(`RL_MODE, 32'h0);
		ser_send(4);
		chk_tx(16'h00ff, 8'h0);
		$display("test serial done");
		print_verdict();
	end
endmodule // test_radio_repeater_compat_select
